//--- mux_seq_defines.svh
// Purpose: constants for the input multiplexer sequencer
// Assumes: included only by the top sequencer module, not by the package or submodules
// Notes: offsets are AXI4-Lite byte addresses
`ifndef MUX_SEQ_DEFINES_SVH
`define MUX_SEQ_DEFINES_SVH
// ----------------------------------------
// register map and fields
// ----------------------------------------
`define ADDR_W 16
`define REG_CTRL 16'h0000
`define REG_SUM 16'h0004
`define REG_STATUS 16'h0008
`define REG_BATT 16'h2020
`define CTRL_SPF_LSB 0
`define CTRL_FLEN_BIT 3
`define CTRL_CHOP_LSB 4
`define CTRL_EQN_LSB 6
`define CTRL_ALT_BIT 8
`define BATT_EN_BIT 6
`define CTRL_RST 9'h00C
`define SUM_RST 8'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// ----------------------------------------
// sequencing figures and result slots
// ----------------------------------------
`define SPF_MIN 3'h2
`define SPF_MAX 3'h4
`define LEN_SHORT 2'h2
`define LEN_LONG 2'h3
`define SLOT_A_CUR 7'h00
`define SLOT_A_VOLT 7'h01
`define SLOT_B_CUR 7'h02
`define SLOT_B_VOLT 7'h03
`define SLOT_TEMP 7'h0A
`define SLOT_VBAT 7'h07
`endif

//--- mux_seq_pkg.sv
// Purpose: shared types of the input multiplexer sequencer
// Assumes: nothing
// Notes: constants live in mux_seq_defines.svh
package mux_seq_pkg;
    // analog source picked by the multiplexer
    typedef enum logic [2:0] {
        SEL_A_CUR = 3'h0,
        SEL_A_VOLT = 3'h1,
        SEL_B_CUR = 3'h2,
        SEL_B_VOLT = 3'h3,
        SEL_TEMP = 3'h4,
        SEL_VBAT = 3'h5
    } mux_sel_t;
    // sequencer phase, one-hot
    typedef enum logic [1:0] {
        ST_CONV = 2'h1,
        ST_SYNC = 2'h2
    } seq_state_t;
    // chopper behaviour
    typedef enum logic [1:0] {
        CHOP_POS = 2'h0,
        CHOP_REV = 2'h1,
        CHOP_TOGGLE = 2'h2,
        CHOP_SPARE = 2'h3
    } chop_mode_t;
endpackage

//--- alt_request_catcher.sv
// Purpose: holds a pending alternate-frame request
// Assumes: request level comes from logic on the same clock
// Notes: a set in the cycle of a take wins over the take
`timescale 1ns/1ps
module alt_request_catcher
    import mux_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request and consumption
    input wire logic req_level,
    input wire logic take,
    output logic pending_q
);
    logic req_prev_q; // last seen request level
    // ----------------------------------------
    // edge detect
    // ----------------------------------------
    // previous level, cleared so a level held high over reset counts as an edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            req_prev_q <= 1'b0;
        else
            req_prev_q <= req_level;
    end
    // ----------------------------------------
    // pending flag
    // ----------------------------------------
    // a one-cycle pulse still leaves an edge here
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pending_q <= 1'b0;
        else if (req_level && !req_prev_q)
            pending_q <= 1'b1;
        else if (take)
            pending_q <= 1'b0;
    end
endmodule

//--- chopper_polarity_ctrl.sv
// Purpose: reference chopper polarity
// Assumes: frame_end pulses once at the start of each sync cycle
// Notes: sum interval length in frames is software set
`timescale 1ns/1ps
module chopper_polarity_ctrl
    import mux_seq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic frame_end,
    input wire chop_mode_t mode,
    input wire logic [7:0] frames_per_sum,
    // polarity
    output logic polarity_q
);
    logic [7:0] frame_cnt_q; // frames done in this sum interval
    logic last_frame; // frame now ending closes the interval
    assign last_frame = (frame_cnt_q >= frames_per_sum - 8'h01);
    // ----------------------------------------
    // sum interval counter
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            frame_cnt_q <= 8'h00;
        else if (frame_end)
            frame_cnt_q <= last_frame ? 8'h00 : frame_cnt_q + 8'h01;
    end
    // ----------------------------------------
    // polarity update, only at frame end
    // ----------------------------------------
    // skipping the toggle at interval end keeps each interval
    // starting on the polarity that the one before ended on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            polarity_q <= 1'b0;
        else if (frame_end)
        begin
            unique case (mode)
                CHOP_POS: polarity_q <= 1'b0;
                CHOP_REV: polarity_q <= 1'b1;
                CHOP_TOGGLE:
                    if (!last_frame)
                        polarity_q <= !polarity_q;
                default: polarity_q <= polarity_q; // spare code holds
            endcase
        end
    end
endmodule

//--- input_mux_sequencer.sv
// Purpose: steps the analog input multiplexer frame by frame
// Assumes: slow timebase arrives as a pin, AXI4-Lite on ref_clk
// Notes: converter, filter and engine are outside this block
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "mux_seq_defines.svh"
module input_mux_sequencer
    import mux_seq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // slow timebase pin
    input wire logic slow_timebase_clock,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`ADDR_W-1:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`ADDR_W-1:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // analog front end control
    output mux_sel_t mux_select,
    output logic battery_monitor_connect,
    output logic conv_start,
    output logic result_store,
    output logic [6:0] result_slot,
    output logic chopper_polarity,
    // engine handshake
    output logic frame_sync,
    output logic engine_start
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta_q; // first reset stage
    logic rst_n; // released reset for the design
    // assert at once, release after two edges
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // slow timebase synchroniser
    // ----------------------------------------
    logic tb_s1_q; // metastable stage, read only by tb_s2_q
    logic tb_s2_q; // second stage
    logic tb_s3_q; // third stage
    logic tb_level_q; // accepted level
    logic tick; // one ref_clk pulse per timebase rising edge
    // three stages, counted when the last two agree
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tb_s1_q <= 1'b0;
            tb_s2_q <= 1'b0;
            tb_s3_q <= 1'b0;
            tb_level_q <= 1'b0;
        end
        else
        begin
            tb_s1_q <= slow_timebase_clock;
            tb_s2_q <= tb_s1_q;
            tb_s3_q <= tb_s2_q;
            if (tb_s2_q == tb_s3_q)
                tb_level_q <= tb_s3_q;
        end
    end
    // all stepping is gated by this tick
    assign tick = (tb_s2_q == tb_s3_q) && tb_s3_q && !tb_level_q;

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic [8:0] ctrl_q; // states, length, chop, equation, alt
    logic [7:0] sum_q; // frames per sum interval
    logic batt_en_q; // battery measure enable
    logic [`ADDR_W-1:0] aw_addr_q; // held write address
    logic [31:0] w_data_q; // held write data
    logic [3:0] w_strb_q; // held byte enables
    logic aw_got_q; // write address taken
    logic w_got_q; // write data taken
    logic wr_fire; // both halves present, respond now
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

    // true when the address names a register
    function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
        is_mapped = (a == `REG_CTRL) || (a == `REG_SUM) ||
                    (a == `REG_STATUS) || (a == `REG_BATT);
    endfunction

    // byte-lane merge of new data into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                merge[i*8 +: 8] = nw[i*8 +: 8];
    endfunction

    // write address channel, taken independently of data
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_got_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            aw_got_q <= 1'b0; // transaction closed
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0; // one write at a time
        end
        else if (!aw_got_q && !s_axi_bvalid)
            s_axi_awready <= 1'b1;
    end

    // write data channel
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_got_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            w_got_q <= 1'b0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (!w_got_q && !s_axi_bvalid)
            s_axi_wready <= 1'b1;
    end

    // write response, two cycles after the later half is taken
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // register update; status is read-only and ignores writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `CTRL_RST;
            sum_q <= `SUM_RST;
            batt_en_q <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (aw_addr_q == `REG_CTRL)
                ctrl_q <= 9'(merge({23'h0, ctrl_q}, w_data_q, w_strb_q));
            if (aw_addr_q == `REG_SUM)
                sum_q <= 8'(merge({24'h0, sum_q}, w_data_q, w_strb_q));
            if (aw_addr_q == `REG_BATT && w_strb_q[0])
                batt_en_q <= w_data_q[`BATT_EN_BIT];
        end
    end

    // decoded control fields
    logic [2:0] spf_raw; // states per frame as written
    logic [2:0] spf; // states per frame in use
    logic flen; // filter length select
    logic [1:0] eqn_sel; // meter equation select
    chop_mode_t chop_mode; // chopper behaviour
    assign spf_raw = ctrl_q[`CTRL_SPF_LSB +: 3];
    assign flen = ctrl_q[`CTRL_FLEN_BIT];
    assign chop_mode = chop_mode_t'(ctrl_q[`CTRL_CHOP_LSB +: 2]);
    assign eqn_sel = ctrl_q[`CTRL_EQN_LSB +: 2];
    // reserved counts are stored as written; clamp to 2..4 keeps the walk bounded
    assign spf = (spf_raw < `SPF_MIN) ? `SPF_MIN :
                 (spf_raw > `SPF_MAX) ? `SPF_MAX : spf_raw;

    // ----------------------------------------
    // alternate request and chopper
    // ----------------------------------------
    logic alt_pending; // request waiting for next frame
    logic frame_begin; // sync cycle ends, state 0 begins
    logic frame_end; // last conversion ends, sync begins

    alt_request_catcher u_alt (
        .clk (ref_clk),
        .rst_n (rst_n),
        .req_level (ctrl_q[`CTRL_ALT_BIT]),
        .take (frame_begin),
        .pending_q (alt_pending)
    );

    chopper_polarity_ctrl u_chop (
        .clk (ref_clk),
        .rst_n (rst_n),
        .frame_end (frame_end),
        .mode (chop_mode),
        .frames_per_sum (sum_q),
        .polarity_q (chopper_polarity)
    );

    // ----------------------------------------
    // frame sequencer
    // ----------------------------------------
    seq_state_t state_q; // converting or in sync cycle
    logic [1:0] idx_q; // multiplexer state within the frame
    logic [1:0] dwell_q; // ticks spent in this conversion
    logic alt_frame_q; // frame in progress is alternate
    logic conv_last; // conversion finishes on this tick
    logic [1:0] conv_len; // ticks per conversion

    // input chosen for a state; equation setting does not change it
    function automatic mux_sel_t pick(input logic [1:0] idx,
                                      input logic alt,
                                      input logic [1:0] eq);
        pick = SEL_A_CUR;
        if (eq <= 2'h3)
        begin
            unique case (idx)
                2'h0: pick = alt ? SEL_TEMP : SEL_A_CUR;
                2'h1: pick = SEL_A_VOLT;
                2'h2: pick = SEL_B_CUR;
                2'h3: pick = alt ? SEL_VBAT : SEL_B_VOLT;
            endcase
        end
    endfunction

    // result location fixed by the source converted
    function automatic logic [6:0] slot_of(input mux_sel_t s);
        unique case (s)
            SEL_A_CUR: slot_of = `SLOT_A_CUR;
            SEL_A_VOLT: slot_of = `SLOT_A_VOLT;
            SEL_B_CUR: slot_of = `SLOT_B_CUR;
            SEL_B_VOLT: slot_of = `SLOT_B_VOLT;
            SEL_TEMP: slot_of = `SLOT_TEMP;
            default: slot_of = `SLOT_VBAT; // battery and spare codes
        endcase
    endfunction

    assign conv_len = flen ? `LEN_LONG : `LEN_SHORT;
    assign conv_last = (state_q == ST_CONV) && tick &&
                       (dwell_q == conv_len - 2'h1);
    assign frame_end = conv_last && ({1'b0, idx_q} == spf - 3'h1);
    assign frame_begin = (state_q == ST_SYNC) && tick;

    // state walk; reset lands on a normal frame at state 0
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_CONV;
            idx_q <= 2'h0;
            dwell_q <= 2'h0;
            alt_frame_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_CONV:
                    if (frame_end)
                        state_q <= ST_SYNC;
                    else if (conv_last)
                    begin
                        idx_q <= idx_q + 2'h1;
                        dwell_q <= 2'h0;
                    end
                    else if (tick)
                        dwell_q <= dwell_q + 2'h1;
                ST_SYNC:
                    if (frame_begin)
                    begin
                        state_q <= ST_CONV;
                        idx_q <= 2'h0;
                        dwell_q <= 2'h0;
                        alt_frame_q <= alt_pending;
                    end
            endcase
        end
    end

    // ----------------------------------------
    // front end outputs, all registered
    // ----------------------------------------
    mux_sel_t cur_sel; // selection of the running state
    assign cur_sel = pick(idx_q, alt_frame_q, eqn_sel);

    // selection and battery load
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mux_select <= SEL_A_CUR;
            battery_monitor_connect <= 1'b0;
        end
        else
        begin
            mux_select <= cur_sel;
            battery_monitor_connect <= batt_en_q;
        end
    end

    // conversion start at each state's first tick
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            conv_start <= 1'b0;
        else
            conv_start <= (state_q == ST_CONV) && tick &&
                          (dwell_q == 2'h0);
    end

    // result store with its slot at conversion end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_store <= 1'b0;
            result_slot <= `SLOT_A_CUR;
        end
        else
        begin
            result_store <= conv_last;
            if (conv_last)
                result_slot <= slot_of(cur_sel);
        end
    end

    // sync held through the extra cycle, engine started at its edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_sync <= 1'b0;
            engine_start <= 1'b0;
        end
        else
        begin
            engine_start <= frame_end;
            if (frame_end)
                frame_sync <= 1'b1;
            else if (frame_begin)
                frame_sync <= 1'b0;
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    // register contents by address; unmapped reads zero
    function automatic logic [31:0] rd_word(input logic [`ADDR_W-1:0] a);
        rd_word = 32'h0000_0000;
        unique case (a)
            `REG_CTRL: rd_word = {23'h0, ctrl_q};
            `REG_SUM: rd_word = {24'h0, sum_q};
            `REG_BATT: rd_word = {25'h0, batt_en_q, 6'h00};
            `REG_STATUS: rd_word = {26'h0, frame_sync, chopper_polarity,
                                    alt_pending, alt_frame_q, idx_q};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction

    // answer one cycle after the address is taken
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word(s_axi_araddr);
            s_axi_rresp <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        else
            s_axi_arready <= 1'b1;
    end
endmodule

//--- seq_chk_asserts.sv
// Purpose: pin timing checks of the input mux sequencer
// Assumes: timebase tick shorter than 40 ref_clk
// Notes: bound to the top module after endmodule
`timescale 1ns/1ps
module seq_chk
    import mux_seq_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // front end pins
    input wire mux_sel_t mux_select,
    input wire logic conv_start,
    input wire logic result_store,
    input wire logic [6:0] result_slot,
    input wire logic frame_sync,
    input wire logic engine_start
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // slot a source lands in, kept apart from the design's own map
    function automatic logic [6:0] slot_of(input mux_sel_t s);
        return s == SEL_TEMP ? 7'h0A : s == SEL_VBAT ? 7'h07 : {4'h0, s};
    endfunction
    a_conv_pulse: assert property (conv_start |=> !conv_start)
        else $error("conv_start too wide");
    a_store_slot: assert property (result_store |-> result_slot == slot_of(mux_select))
        else $error("wrong result slot");
    a_sync_start: assert property ($rose(frame_sync) |-> engine_start && result_store)
        else $error("sync start mismatch");
    a_engine_once: assert property (engine_start |-> frame_sync ##1 !engine_start)
        else $error("engine start mismatch");
    a_no_conv_sync: assert property (frame_sync |-> !conv_start)
        else $error("conversion during sync");
    a_sync_hold: assert property ($rose(frame_sync) |=>
        frame_sync [*8] ##[1:40] !frame_sync)
        else $error("sync length wrong");
    a_frame_restart: assert property ($fell(frame_sync) |-> ##[1:40] conv_start
        ##[1:80] (result_store && result_slot inside {7'h00, 7'h0A}))
        else $error("frame did not restart");
    a_sel_legal: assert property (mux_select <= SEL_VBAT)
        else $error("illegal selection");
    // main scenarios reached
    c_frame: cover property (engine_start);
    c_temp: cover property (result_store && result_slot == 7'h0A);
    c_batt: cover property (result_store && result_slot == 7'h07);
endmodule
bind input_mux_sequencer seq_chk chk(.ref_clk, .arst_n, .mux_select, .conv_start,
    .result_store, .result_slot, .frame_sync, .engine_start);

//--- timebase_src.sv
// Purpose: slow timebase source feeding the sequencer pin
// Assumes: free running, phase unrelated to ref_clk
// Notes: far faster than the real timebase to keep runs short
`timescale 1ns/1ps
module timebase_src
(
    // timebase and tick count
    output logic tb_clk,
    output int ticks
);
    // free running clock, counts its rising edges
    initial
    begin
        tb_clk = 0;
        ticks = 0;
        #7;
        forever
        begin
            #250 tb_clk = ~tb_clk;
            if (tb_clk)
                ticks++;
        end
    end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench of the input mux sequencer
// Assumes: bench plays the processor over AXI4-Lite
// Notes: frames are judged between engine start pulses
`timescale 1ns/1ps
module tb_top
    import mux_seq_pkg::*;
;
    // bus master side and design outputs
    logic ref_clk = 0, arst_n = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [15:0] aa = 0, ra = 0;
    logic [31:0] wd = 0, rd;
    logic awr, wr, bv, arr, rv, bmc, cs, rs, pol, fs, es, tck;
    logic [1:0] br, rr;
    logic [6:0] slot;
    mux_sel_t sel;
    mux_sel_t seq[$];
    int ticks, num_errors = 0, samples_checked = 0;
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    timebase_src src(.tb_clk(tck), .ticks(ticks));
    input_mux_sequencer uut(.ref_clk, .arst_n, .slow_timebase_clock(tck),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(aa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ra), .s_axi_rvalid(rv), .s_axi_rready(rre), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .mux_select(sel), .battery_monitor_connect(bmc),
        .conv_start(cs), .result_store(rs), .result_slot(slot), .chopper_polarity(pol),
        .frame_sync(fs), .engine_start(es));
    task automatic give_verdict();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // a wait that ran out ends the run
    task automatic stuck();
        chk(32'h0, 32'h1);
        give_verdict();
    endtask
    task automatic wt(ref logic s);
        int i;
        for (i = 0; i < 3000 && s !== 1'b1; i++)
            @(posedge ref_clk) #1;
        if (i == 3000)
            stuck();
    endtask
    // one write, each half released when taken
    task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
        int i;
        @(posedge ref_clk);
        {awv, wv, bre, aa, wd} <= {3'b111, a, d};
        for (i = 0; i < 99; i++)
        begin
            @(posedge ref_clk);
            if (awr)
                awv <= 0;
            if (wr)
                wv <= 0;
            if (bv)
                break;
        end
        bre <= 0;
        if (i == 99)
            stuck();
        chk(br, e);
    endtask
    task automatic axr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] e);
        int i;
        @(posedge ref_clk);
        {arv, rre, ra} <= {2'b11, a};
        for (i = 0; i < 99; i++)
        begin
            @(posedge ref_clk);
            if (arr)
                arv <= 0;
            if (rv)
                break;
        end
        rre <= 0;
        if (i == 99)
            stuck();
        chk(rd, d);
        chk(rr, e);
    endtask
    function automatic mux_sel_t exp_sel(input logic alt, input int i);
        if (alt && i == 0)
            return SEL_TEMP;
        if (alt && i == 3)
            return SEL_VBAT;
        return mux_sel_t'(i[2:0]);
    endfunction
    // skip to a frame end, then record the next whole frame
    task automatic look(input int n, input int l, input logic alt);
        int i, t0;
        @(posedge ref_clk) #1;
        wt(es);
        t0 = ticks;
        seq = {};
        for (i = 0; i < 3000; i++)
        begin
            @(posedge ref_clk) #1;
            if (rs)
                seq.push_back(sel);
            if (es)
                break;
        end
        if (i == 3000)
            stuck();
        chk(seq.size(), n);
        chk(ticks - t0, n * (l ? 3 : 2) + 1);
        for (i = 0; i < n; i++)
            chk(seq[i], exp_sel(alt, i));
    endtask
    initial
    begin
        int k, n, l, q;
        void'($urandom(51));
        repeat (16) @(posedge ref_clk);
        arst_n <= 1;
        repeat (4) @(posedge ref_clk);
        axr(16'h0000, 32'h0000000C, 2'h0);
        axr(16'h0004, 32'h00000010, 2'h0);
        axr(16'h0100, 32'h00000000, 2'h2);
        axw(16'h0100, 32'h00000001, 2'h2);
        axw(16'h0004, 32'h000000FF, 2'h0);
        look(4, 1, 0);
        $display("registers and reset frame done");
        for (k = 0; k < 6; k++)
        begin
            n = 2 + k % 3;
            l = k / 3;
            q = n | l << 3 | ($urandom % 3) << 6;
            axw(16'h0000, q, 2'h0);
            look(n, l, 0);
            wt(cs);
            axw(16'h0000, q | 32'h100, 2'h0);
            axw(16'h0000, q, 2'h0);
            look(n, l, 1);
            look(n, l, 0);
        end
        $display("frame sequences done");
        axw(16'h2020, 32'h00000040, 2'h0);
        axr(16'h2020, 32'h00000040, 2'h0);
        chk(bmc, 1'b1);
        axw(16'h2020, 32'h00000000, 2'h0);
        axr(16'h2020, 32'h00000000, 2'h0);
        chk(bmc, 1'b0);
        axw(16'h0000, 32'h0000000C, 2'h0);
        look(4, 1, 0);
        chk(pol, 1'b0);
        axw(16'h0000, 32'h0000001C, 2'h0);
        look(4, 1, 0);
        chk(pol, 1'b1);
        axw(16'h0000, 32'h0000002C, 2'h0);
        look(4, 1, 0);
        chk(pol, 1'b1);
        axw(16'h0000, 32'h0000003C, 2'h0);
        look(4, 1, 0);
        chk(pol, 1'b1);
        axw(16'h0000, 32'h0000002C, 2'h0);
        @(posedge ref_clk) #1;
        wt(es);
        chk(pol, 1'b0);
        axw(16'h0004, 32'h00000001, 2'h0);
        look(4, 1, 0);
        chk(pol, 1'b0);
        $display("battery and chopper done");
        give_verdict();
    end
endmodule
